// ==== rtl/sbsc_core.sv ====
// module: subtract-with-borrow and string scan-compare datapath with Avalon-MM registers
`timescale 1ns/1ns

// Operation
// - opcode AE scans low accumulator byte against extra_segment:dest_index, 15/19 clocks.
// - opcode AF scans whole accumulator word the same way, same clock counts.
// - scan subtracts memory from accumulator, drops the difference, updates only flags and dest_index.
// - scan memory always uses extra_segment; segment override ignored.
// - scan address is the live dest_index value; operand only chooses size.
// - after scan dest_index rises when direction_flag is 0, falls when 1.
// - dest_index step is 1 for bytes, 2 for words, wrapping at 16 bits.
// - operand-free byte and word scans decode to the very same operations.
// - subtract-with-borrow sets carry_flag on borrow out of the top bit.
// - subtract-with-borrow sets overflow_flag when signed result does not fit.
// - subtract-with-borrow sets zero_flag exactly when the result is zero.
// - subtract-with-borrow sets aux_carry_flag on borrow out of the low nibble.
// - operands share one size; byte immediate with word destination is sign-extended.
// - result is destination minus source minus carry_flag, written to destination.
// - sign extension fills the upper byte with ones for negative bytes.
module sbsc_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic core_ce,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // memory operand port toward the bus unit
  output logic mem_req,
  output logic [19:0] mem_addr,
  output logic mem_word,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // status
  output logic busy
);

  // ==========================================================================
  // registers and state
  // ==========================================================================
  sbsc_pkg::sbsc_state_t state_q;
  sbsc_pkg::sbsc_flags_t flags_q;
  sbsc_pkg::sbsc_alu_t alu;
  logic [15:0] ctrl_q;
  logic [15:0] accum_q;
  logic [15:0] dest_q;
  logic [15:0] src_q;
  logic [15:0] di_q;
  logic [15:0] es_q;
  logic [15:0] ovr_q;
  logic [15:0] opnd_q;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic is_scan_q;
  logic word_q;
  logic sext_q;
  logic badop_q;
  logic rd_valid_q;
  logic [31:0] rdata_q;
  logic [5:0] len_q;

  logic wr_go;
  logic start_go;
  logic done;
  logic [7:0] opc;
  logic op_known;
  logic op_scan;
  logic op_word;
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  logic [15:0] di_step;
  localparam sbsc_pkg::sbsc_flags_t RST_FLAGS_T = sbsc_pkg::RST_FLAGS;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // ==========================================================================
  // bus slave
  // ==========================================================================
  assign busy = (state_q != sbsc_pkg::SBSC_IDLE);
  assign avs_waitrequest = avs_read ? !rd_valid_q : (avs_write && busy);
  assign avs_readdata = rdata_q;
  assign wr_go = avs_write && !avs_read && !busy;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_valid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (core_ce) begin
      rd_valid_q <= avs_read && !rd_valid_q;
      if (avs_read && !rd_valid_q) begin
        case (avs_address)
          sbsc_pkg::REG_CTRL: rdata_q <= {16'h0000, ctrl_q};
          sbsc_pkg::REG_ACCUM: rdata_q <= {16'h0000, accum_q};
          sbsc_pkg::REG_DEST: rdata_q <= {16'h0000, dest_q};
          sbsc_pkg::REG_SRC: rdata_q <= {16'h0000, src_q};
          sbsc_pkg::REG_DEST_INDEX: rdata_q <= {16'h0000, di_q};
          sbsc_pkg::REG_EXTRA_SEG: rdata_q <= {16'h0000, es_q};
          sbsc_pkg::REG_OVERRIDE_SEG: rdata_q <= {16'h0000, ovr_q};
          sbsc_pkg::REG_FLAGS: rdata_q <= {16'h0000, flags_q};
          sbsc_pkg::REG_STATUS: rdata_q <= {30'h0000_0000, badop_q, busy};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control word; start bit is a self-clearing trigger
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= sbsc_pkg::RST_WORD;
    end else if (core_ce) begin
      if (wr_go && avs_address == sbsc_pkg::REG_CTRL) begin
        ctrl_q <= merge16(ctrl_q, avs_writedata, avs_byteenable);
        ctrl_q[sbsc_pkg::CTRL_START_BIT] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // decode
  // ==========================================================================
  assign opc = avs_byteenable[0] ? avs_writedata[7:0] : ctrl_q[7:0];
  // bare scan mnemonics share these opcodes, so no separate path exists
  assign op_scan = (opc == sbsc_pkg::OP_SCAN_BYTE) || (opc == sbsc_pkg::OP_SCAN_WORD);
  assign op_word = (opc == sbsc_pkg::OP_SCAN_WORD) || (opc == sbsc_pkg::OP_SBB_WORD)
                   || (opc == sbsc_pkg::OP_SBB_WORD_SEXT);
  assign op_known = op_scan || (opc == sbsc_pkg::OP_SBB_BYTE) || op_word;
  assign start_go = wr_go && avs_address == sbsc_pkg::REG_CTRL && avs_byteenable[1]
                    && avs_writedata[sbsc_pkg::CTRL_START_BIT];

  // ==========================================================================
  // sequencer
  // ==========================================================================
  assign done = (state_q == sbsc_pkg::SBSC_EXEC) && (cnt_q == 5'h00);

  always_comb begin
    cnt_d = cnt_q;
    if (start_go) begin
      if (op_scan) begin
        cnt_d = (avs_writedata[sbsc_pkg::CTRL_NARROW_BIT] ? sbsc_pkg::CYC_SCAN_NARROW
                 : sbsc_pkg::CYC_SCAN_WIDE) - 5'h01;
      end else begin
        cnt_d = (op_word ? sbsc_pkg::CYC_SBB_WORD : sbsc_pkg::CYC_SBB_BYTE) - 5'h01;
      end
    end else if (busy && cnt_q != 5'h00) begin
      cnt_d = cnt_q - 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= sbsc_pkg::SBSC_IDLE;
      cnt_q <= 5'h00;
      is_scan_q <= 1'b0;
      word_q <= 1'b0;
      sext_q <= 1'b0;
      badop_q <= 1'b0;
    end else if (core_ce) begin
      cnt_q <= cnt_d;
      case (state_q)
        sbsc_pkg::SBSC_IDLE: begin
          if (start_go) begin
            badop_q <= !op_known;
            is_scan_q <= op_scan;
            word_q <= op_word;
            sext_q <= (opc == sbsc_pkg::OP_SBB_WORD_SEXT);
            if (op_known) begin
              state_q <= op_scan ? sbsc_pkg::SBSC_FETCH : sbsc_pkg::SBSC_EXEC;
            end
          end
        end
        sbsc_pkg::SBSC_FETCH: begin
          if (mem_ack) begin
            state_q <= sbsc_pkg::SBSC_EXEC;
          end
        end
        sbsc_pkg::SBSC_EXEC: begin
          if (cnt_q == 5'h00) begin
            state_q <= sbsc_pkg::SBSC_IDLE;
          end
        end
        default: state_q <= sbsc_pkg::SBSC_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // memory operand fetch
  // ==========================================================================
  // override register is never consulted: the segment is fixed
  assign mem_req = (state_q == sbsc_pkg::SBSC_FETCH);
  assign mem_addr = {es_q, 4'h0} + {4'h0, di_q};
  assign mem_word = word_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      opnd_q <= sbsc_pkg::RST_WORD;
    end else if (core_ce) begin
      if (mem_req && mem_ack) begin
        opnd_q <= mem_rdata;
      end
    end
  end

  // ==========================================================================
  // arithmetic
  // ==========================================================================
  assign alu_a = is_scan_q ? accum_q : dest_q;
  always_comb begin
    if (is_scan_q) begin
      alu_b = opnd_q;
    end else if (sext_q) begin
      alu_b = {src_q[7] ? 8'hFF : 8'h00, src_q[7:0]};
    end else begin
      alu_b = src_q;
    end
  end

  sbsc_sub_alu u_alu (
    .minuend(alu_a),
    .subtrahend(alu_b),
    .borrow_in(is_scan_q ? 1'b0 : flags_q.cry),
    .word_op(word_q),
    .outcome(alu)
  );

  assign di_step = word_q ? 16'h0002 : 16'h0001;

  // ==========================================================================
  // architectural registers
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      accum_q <= sbsc_pkg::RST_WORD;
      src_q <= sbsc_pkg::RST_WORD;
      es_q <= sbsc_pkg::RST_WORD;
      ovr_q <= sbsc_pkg::RST_WORD;
    end else if (core_ce && wr_go) begin
      case (avs_address)
        sbsc_pkg::REG_ACCUM: accum_q <= merge16(accum_q, avs_writedata, avs_byteenable);
        sbsc_pkg::REG_SRC: src_q <= merge16(src_q, avs_writedata, avs_byteenable);
        sbsc_pkg::REG_EXTRA_SEG: es_q <= merge16(es_q, avs_writedata, avs_byteenable);
        sbsc_pkg::REG_OVERRIDE_SEG: ovr_q <= merge16(ovr_q, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  // destination: only subtract-with-borrow writes back; byte form keeps upper half
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dest_q <= sbsc_pkg::RST_WORD;
    end else if (core_ce) begin
      if (done && !is_scan_q) begin
        dest_q <= word_q ? alu.result : {dest_q[15:8], alu.result[7:0]};
      end else if (wr_go && avs_address == sbsc_pkg::REG_DEST) begin
        dest_q <= merge16(dest_q, avs_writedata, avs_byteenable);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      di_q <= sbsc_pkg::RST_WORD;
    end else if (core_ce) begin
      if (done && is_scan_q) begin
        di_q <= flags_q.dir ? di_q - di_step : di_q + di_step;
      end else if (wr_go && avs_address == sbsc_pkg::REG_DEST_INDEX) begin
        di_q <= merge16(di_q, avs_writedata, avs_byteenable);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_q <= RST_FLAGS_T;
    end else if (core_ce) begin
      if (done) begin
        flags_q.cry <= alu.cry;
        flags_q.ovf <= alu.ovf;
        flags_q.zro <= alu.zro;
        flags_q.aux <= alu.aux;
        flags_q.sgn <= alu.sgn;
        flags_q.par <= alu.par;
      end else if (wr_go && avs_address == sbsc_pkg::REG_FLAGS) begin
        flags_q <= merge16(flags_q, avs_writedata, avs_byteenable);
      end
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      len_q <= 6'h00;
    end else if (core_ce) begin
      len_q <= start_go ? 6'h01 : (busy ? len_q + 6'h01 : len_q);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || !core_ce);

  sequence s_scan_commit;
    done && is_scan_q;
  endsequence

  sequence s_sbb_commit;
    done && !is_scan_q;
  endsequence

  a_scan_di_step: assert property (s_scan_commit |=> di_q == ($past(flags_q.dir) ?
      $past(di_q) - $past(di_step) : $past(di_q) + $past(di_step)))
    else $error("dest_index not stepped correctly after scan");

  a_scan_no_write: assert property (s_scan_commit |=> $stable(dest_q) && $stable(accum_q))
    else $error("scan compare wrote a data register");

  a_scan_seg_addr: assert property (mem_req |-> mem_addr == {es_q, 4'h0} + {4'h0, di_q})
    else $error("scan operand address not extra_segment:dest_index");

  a_scan_cycle_count: assert property (s_scan_commit |-> len_q >=
      (ctrl_q[sbsc_pkg::CTRL_NARROW_BIT] ? 6'h13 : 6'h0F))
    else $error("scan finished before its clock count");

  a_sbb_writeback: assert property (s_sbb_commit ##1 1'b1 |-> word_q ?
      dest_q == $past(alu.result) : dest_q[7:0] == $past(alu.result[7:0]))
    else $error("subtract-with-borrow result not written back");

  a_sbb_carry_flag: assert property (s_sbb_commit |=> flags_q.cry == $past(alu.cry))
    else $error("carry_flag does not follow the borrow");

  a_sbb_zero_flag: assert property (s_sbb_commit |=> flags_q.zro ==
      (word_q ? dest_q == 16'h0000 : dest_q[7:0] == 8'h00))
    else $error("zero_flag disagrees with the result");

  a_parity_low_byte: assert property (done |=> flags_q.par == ~^$past(alu.result[7:0]))
    else $error("parity_flag wrong");

  a_ctl_flags_keep: assert property (done |=> $stable(flags_q.dir) && $stable(flags_q.ien)
      && $stable(flags_q.trap))
    else $error("control flags changed by arithmetic");

endmodule : sbsc_core

// ==== rtl/sbsc_pkg.sv ====
// package: constants and carrier types for the subtract-with-borrow and scan-compare datapath
package sbsc_pkg;

  // ==========================================================================
  // register map (byte addresses on the Avalon-MM slave)
  // ==========================================================================
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_ACCUM = 6'h04;
  localparam logic [5:0] REG_DEST = 6'h08;
  localparam logic [5:0] REG_SRC = 6'h0C;
  localparam logic [5:0] REG_DEST_INDEX = 6'h10;
  localparam logic [5:0] REG_EXTRA_SEG = 6'h14;
  localparam logic [5:0] REG_OVERRIDE_SEG = 6'h18;
  localparam logic [5:0] REG_FLAGS = 6'h1C;
  localparam logic [5:0] REG_STATUS = 6'h20;

  // ==========================================================================
  // opcodes
  // ==========================================================================
  localparam logic [7:0] OP_SCAN_BYTE = 8'hAE;
  localparam logic [7:0] OP_SCAN_WORD = 8'hAF;
  localparam logic [7:0] OP_SBB_BYTE = 8'h1C;
  localparam logic [7:0] OP_SBB_WORD = 8'h1D;
  localparam logic [7:0] OP_SBB_WORD_SEXT = 8'h83;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int CTRL_START_BIT = 8;
  localparam int CTRL_NARROW_BIT = 9;
  localparam int CTRL_OVERRIDE_BIT = 10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BADOP_BIT = 1;
  localparam int SEG_SHIFT = 4;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;

  // ==========================================================================
  // cycle counts at the core clock
  // ==========================================================================
  localparam logic [4:0] CYC_SCAN_WIDE = 5'h0F;
  localparam logic [4:0] CYC_SCAN_NARROW = 5'h13;
  localparam logic [4:0] CYC_SBB_BYTE = 5'h03;
  localparam logic [4:0] CYC_SBB_WORD = 5'h04;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {
    SBSC_IDLE = 2'b00,
    SBSC_FETCH = 2'b01,
    SBSC_EXEC = 2'b11
  } sbsc_state_t;

  // status word layout, bit 15 down to bit 0
  typedef struct packed {
    logic [3:0] rsv_hi;
    logic ovf;
    logic dir;
    logic ien;
    logic trap;
    logic sgn;
    logic zro;
    logic rsv5;
    logic aux;
    logic rsv3;
    logic par;
    logic rsv1;
    logic cry;
  } sbsc_flags_t;

  // arithmetic outcome of one subtraction
  typedef struct packed {
    logic [15:0] result;
    logic cry;
    logic ovf;
    logic aux;
    logic zro;
    logic sgn;
    logic par;
  } sbsc_alu_t;

endpackage : sbsc_pkg

// ==== rtl/sbsc_sub_alu.sv ====
// module: byte or word subtractor with borrow-in and arithmetic flags
`timescale 1ns/1ns

module sbsc_sub_alu (
  // operands
  input wire logic [15:0] minuend,
  input wire logic [15:0] subtrahend,
  input wire logic borrow_in,
  input wire logic word_op,
  // outcome
  output sbsc_pkg::sbsc_alu_t outcome
);

  logic [8:0] diff9;
  logic [16:0] diff17;
  logic [15:0] res;
  logic a_msb;
  logic b_msb;
  logic r_msb;

  assign diff9 = {1'b0, minuend[7:0]} - {1'b0, subtrahend[7:0]} - {8'h00, borrow_in};
  assign diff17 = {1'b0, minuend} - {1'b0, subtrahend} - {16'h0000, borrow_in};
  assign res = word_op ? diff17[15:0] : {8'h00, diff9[7:0]};
  assign a_msb = word_op ? minuend[15] : minuend[7];
  assign b_msb = word_op ? subtrahend[15] : subtrahend[7];
  assign r_msb = word_op ? res[15] : res[7];

  assign outcome.result = res;
  assign outcome.cry = word_op ? diff17[16] : diff9[8];
  assign outcome.ovf = (a_msb ^ b_msb) & (a_msb ^ r_msb);
  assign outcome.aux = minuend[4] ^ subtrahend[4] ^ res[4];
  assign outcome.zro = (res == 16'h0000);
  assign outcome.sgn = r_msb;
  assign outcome.par = ~^res[7:0];

endmodule : sbsc_sub_alu

// ==== tb/sbsc_bus_model.sv ====
// bus unit model: answers scan operand requests after a settable delay
`timescale 1ns/1ns

module sbsc_bus_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // settings from the bench
  input wire logic [7:0] ack_delay,
  // operand port
  input wire logic mem_req,
  input wire logic [19:0] mem_addr,
  input wire logic mem_word,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [7:0] wait_q;
  logic [15:0] data_q;
  logic [19:0] next_addr;

  assign next_addr = mem_addr + 20'h00001;
  // released data lines show the inverse of the last value
  assign mem_rdata = mem_ack ? data_q : ~data_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      wait_q <= 8'h00;
      data_q <= 16'h0000;
    end else if (mem_req && !mem_ack) begin
      if (wait_q >= ack_delay) begin
        mem_ack <= 1'b1;
        data_q <= {mem_word ? next_addr[7:0] ^ 8'hC3 : ~data_q[15:8], mem_addr[7:0] ^ 8'hC3};
      end else begin
        wait_q <= wait_q + 8'h01;
      end
    end else begin
      mem_ack <= 1'b0;
      wait_q <= 8'h00;
    end
  end
endmodule : sbsc_bus_model

// ==== tb/sbsc_core_tb.sv ====
// testbench: register-level tests of subtract-with-borrow and scan compare
`timescale 1ns/1ns

module sbsc_core_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic core_ce = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mem_req;
  logic [19:0] mem_addr;
  logic mem_word;
  logic mem_ack;
  logic [15:0] mem_rdata;
  logic busy;
  logic [7:0] ack_delay = 8'h02;
  logic [19:0] seen_addr;
  logic seen_word;
  logic [31:0] rd;
  int miscompares = 0;
  int cmp_count = 0;

  always #10 core_clk = ~core_clk;

  sbsc_core sbsc_core_inst (.core_clk(core_clk), .sys_rst(sys_rst), .core_ce(core_ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_word(mem_word), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .busy(busy));

  sbsc_bus_model sbsc_bus_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .ack_delay(ack_delay), .mem_req(mem_req), .mem_addr(mem_addr), .mem_word(mem_word),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // each transfer starts one edge after the previous one was released
  task automatic bus_write(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= 4'h3;
    avs_write <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [5:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_read

  // start an operation and count the cycles that busy stays high
  task automatic run_op(input logic [15:0] ctrl, output int n);
    bus_write(sbsc_pkg::REG_CTRL, ctrl);
    n = 0;
    for (int i = 0; i < 100; i++) begin
      @(posedge core_clk);
      if (mem_req === 1'b1) begin
        seen_addr = mem_addr;
        seen_word = mem_word;
      end
      if (busy !== 1'b1) break;
      n++;
    end
  endtask : run_op

  // reference subtraction: {result, flags}
  function automatic logic [31:0] ref_sub(input logic [15:0] a, input logic [15:0] b,
                                          input logic cin, input logic w);
    logic [16:0] full;
    logic [4:0] nib;
    logic [15:0] r;
    logic [15:0] f;
    full = w ? {1'b0, a} - {1'b0, b} - cin : {9'h000, a[7:0]} - {9'h000, b[7:0]} - cin;
    nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - cin;
    r = w ? full[15:0] : {8'h00, full[7:0]};
    f = 16'h0000;
    f[0] = w ? full[16] : full[8];
    f[2] = ~^r[7:0];
    f[4] = nib[4];
    f[6] = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
    f[7] = w ? r[15] : r[7];
    f[11] = w ? (a[15] ^ b[15]) & (a[15] ^ r[15]) : (a[7] ^ b[7]) & (a[7] ^ r[7]);
    return {r, f};
  endfunction : ref_sub

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // {opcode, dest, src, borrow in}
  logic [47:0] sbb_tab [7] = '{48'h1C_1234_0035_00, 48'h1C_0080_0001_00, 48'h1C_0011_0010_01,
    48'h1D_8000_0001_01, 48'h1D_0000_FFFF_01, 48'h83_0005_00FE_00, 48'h83_0005_007F_00};
  // {opcode, accum, dest_index, extra_segment, cfg: 0 df, 1 narrow, 2 override, 3 slow}
  logic [63:0] scan_tab [4] = '{64'hAE_55D3_0010_1000_00, 64'hAF_1234_FFFF_F000_02,
    64'hAE_0001_0000_0234_07, 64'hAF_8000_0001_0100_09};

  initial begin : watchdog
    repeat (20000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end

  initial begin : tests
    logic [7:0] op;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] di;
    logic [15:0] es;
    logic [7:0] cfg;
    logic [31:0] e;
    logic w;
    int n;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus_read(sbsc_pkg::REG_FLAGS, rd);
    check(rd, 32'h00000000);
    bus_read(sbsc_pkg::REG_DEST_INDEX, rd);
    check(rd, 32'h00000000);
    bus_read(6'h24, rd);
    check(rd, 32'h00000000);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      op = sbb_tab[i][47:40];
      a = sbb_tab[i][39:24];
      b = sbb_tab[i][23:8];
      w = (op != sbsc_pkg::OP_SBB_BYTE);
      if (op == sbsc_pkg::OP_SBB_WORD_SEXT) b = {{8{b[7]}}, b[7:0]};
      bus_write(sbsc_pkg::REG_DEST, a);
      bus_write(sbsc_pkg::REG_SRC, sbb_tab[i][23:8]);
      bus_write(sbsc_pkg::REG_FLAGS, 16'h0700 | {15'h0000, sbb_tab[i][0]});
      run_op({8'h01, op}, n);
      check(n, w ? 32'h4 : 32'h3);
      e = ref_sub(a, b, sbb_tab[i][0], w);
      bus_read(sbsc_pkg::REG_DEST, rd);
      check(rd, {16'h0000, w ? e[31:16] : {a[15:8], e[23:16]}});
      bus_read(sbsc_pkg::REG_FLAGS, rd);
      check(rd, {16'h0000, 16'h0700 | e[15:0]});
    end
    $display("test sub_with_borrow done");
    run_op(16'h0190, n);
    check(n, 32'h0);
    bus_read(sbsc_pkg::REG_STATUS, rd);
    check(rd, 32'h00000002);
    $display("test bad opcode done");
    // clock enable low must hold a running byte subtraction in place
    bus_write(sbsc_pkg::REG_CTRL, 16'h011C);
    core_ce <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(busy, 1'b1);
    core_ce <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(busy, 1'b0);
    $display("test clock enable done");
    for (int i = 0; i < 4; i++) begin
      {op, a, di, es, cfg} = scan_tab[i];
      w = op[0];
      ack_delay <= cfg[3] ? 8'h18 : 8'h02;
      bus_write(sbsc_pkg::REG_ACCUM, a);
      bus_write(sbsc_pkg::REG_DEST_INDEX, di);
      bus_write(sbsc_pkg::REG_EXTRA_SEG, es);
      bus_write(sbsc_pkg::REG_OVERRIDE_SEG, 16'h7777);
      bus_write(sbsc_pkg::REG_FLAGS, 16'h0301 | {5'h00, cfg[0], 10'h000});
      run_op({5'h00, cfg[2], cfg[1], 1'b1, op}, n);
      e = {12'h000, es, 4'h0} + {16'h0000, di};
      check(seen_addr, e[19:0]);
      check(seen_word, w);
      if (cfg[3]) check(n > 15, 1'b1);
      else check(n, cfg[1] ? 32'h13 : 32'h0F);
      b = e[15:0] + 16'h0001;
      b = {b[7:0] ^ 8'hC3, e[7:0] ^ 8'hC3};
      e = ref_sub(a, b, 1'b0, w);
      bus_read(sbsc_pkg::REG_FLAGS, rd);
      check(rd, {16'h0000, 16'h0300 | {5'h00, cfg[0], 10'h000} | e[15:0]});
      bus_read(sbsc_pkg::REG_ACCUM, rd);
      check(rd, {16'h0000, a});
      bus_read(sbsc_pkg::REG_DEST_INDEX, rd);
      e = cfg[0] ? di - (w ? 16'h2 : 16'h1) : di + (w ? 16'h2 : 16'h1);
      check(rd, {16'h0000, e[15:0]});
      bus_read(sbsc_pkg::REG_STATUS, rd);
      check(rd, 32'h00000000);
    end
    $display("test scan_compare done");
    complete_run();
  end
endmodule : sbsc_core_tb
